// File: common/sst_defs.svh
`ifndef SST_DEFS_SVH
`define SST_DEFS_SVH
// Function
// - Global shutter starts every sensor line at one common instant per frame.
// - Global shutter: exposure-active high from exposure start to exposure end.
// - Rolling shutter: first line starts at trigger, each next one offset later.
// - Rolling shutter: every line exposes for the same duration.
// - Row start offset equals the per-line time of 29.479166 us.
// - Flash window opens row offset times (line count minus one) after trigger.
// - Line count is the programmed region height plus eight.
// - Flash window lasts exposure minus row offset times (line count minus one).
// - No strobe in a flash-window frame whose exposure does not exceed that product.
// - In flash-window mode the strobe never leaves the flash window; delay and duration only narrow it.
// - Flash-window mode drives the window pulse on the output port in each frame that has a window.
// - Exposure-active mode drives exposure-active on the output port in rolling shutter only; global ignores the mode bit.
// - Rolling exposure-active spans first row start to last row end.
// - Rolling exposure-active ignores strobe delay and duration.
// - Strobe waits the programmed delay in microseconds after capture start.
// - Strobe stays high for the programmed duration in microseconds; global shutter cuts it off at exposure end.
// - All strobe output ports share one delay and one duration.
`define SST_CLK_PERIOD_PS 4000
`define SST_PS_PER_US 1000000
`define SST_CYC_PER_US (`SST_PS_PER_US / `SST_CLK_PERIOD_PS)
`define SST_ROW_OFFSET_PS 29479166
`define SST_ROW_OFFSET_CYC (`SST_ROW_OFFSET_PS / `SST_CLK_PERIOD_PS)
`define SST_ROI_PAD 8
`define SST_TW 32
`define SST_US_W 20
`define SST_ROI_W 12
`define SST_LINE_W 13
`define SST_CNT_W 16
`define SST_N_OUT 2
`define SST_AW 8
`define SST_REG_CTRL 8'h00
`define SST_REG_ROI 8'h04
`define SST_REG_EXPOSURE 8'h08
`define SST_REG_DELAY 8'h0c
`define SST_REG_DURATION 8'h10
`define SST_REG_STATUS 8'h14
`define SST_REG_FLASHOPEN 8'h18
`define SST_REG_MISSED 8'h1c
`define SST_REG_ELAPSED 8'h20
`define SST_CTRL_EN 0
`define SST_CTRL_ROLL 1
`define SST_CTRL_FLASH 2
`define SST_CTRL_SWTRIG 3
`define SST_CTRL_PORT_LSB 8
`define SST_ST_BUSY 0
`define SST_ST_EXPACT 1
`define SST_ST_STROBE 2
`define SST_ST_NOWIN 3
`define SST_ST_FRAMES_LSB 16
`define SST_ROI_RST 12'h100
`define SST_EXP_RST 20'h003e8
`define SST_DLY_RST 20'h00000
`define SST_DUR_RST 20'h00064
`define SST_PORT_RST 2'h1
`endif

// File: common/sst_pkg.sv
`include "sst_defs.svh"
package sst_pkg;
    typedef enum logic {SST_IDLE, SST_RUN} sst_phase_t;

    typedef struct packed {
        sst_phase_t phase;
        logic rolling;
        logic flash;
        logic noWin;
        logic strobe;
        logic expAct;
        logic lineStart;
        logic lineEnd;
        logic [`SST_TW-1:0] elapsed;
        logic [`SST_TW-1:0] expC;
        logic [`SST_TW-1:0] expEnd;
        logic [`SST_TW-1:0] fwOpen;
        logic [`SST_TW-1:0] sStart;
        logic [`SST_TW-1:0] sEnd;
        logic [`SST_TW-1:0] startTgt;
        logic [`SST_TW-1:0] endTgt;
        logic [`SST_LINE_W-1:0] lines;
        logic [`SST_LINE_W-1:0] startRow;
        logic [`SST_LINE_W-1:0] endRow;
        logic [`SST_CNT_W-1:0] frameCnt;
    } sst_tim_t;

    typedef struct packed {
        logic en;
        logic rolling;
        logic flash;
        logic swTrig;
        logic [`SST_N_OUT-1:0] portSel;
        logic [`SST_ROI_W-1:0] roi;
        logic [`SST_US_W-1:0] expUs;
        logic [`SST_US_W-1:0] dlyUs;
        logic [`SST_US_W-1:0] durUs;
        logic noWinSticky;
        logic [`SST_CNT_W-1:0] missed;
        logic dpValid;
        logic dpWrite;
        logic [`SST_AW-1:0] dpAddr;
        logic [31:0] rdata;
        logic sy1;
        logic sy2;
        logic sy3;
        logic trigLvl;
        logic trigPulse;
        logic [`SST_N_OUT-1:0] strobeOut;
    } sst_regs_t;
endpackage

// File: src/sst_timing.sv
`timescale 1ns/1ps
`include "sst_defs.svh"
module sst_timing #(
    parameter logic [`SST_TW-1:0] ROW_OFFSET_CYC = `SST_ROW_OFFSET_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic trig,
    input wire logic enable,
    input wire logic rolling,
    input wire logic flashMode,
    input wire logic [`SST_ROI_W-1:0] roiHeight,
    input wire logic [`SST_US_W-1:0] expUs,
    input wire logic [`SST_US_W-1:0] dlyUs,
    input wire logic [`SST_US_W-1:0] durUs,
    output logic strobe,
    output logic expAct,
    output logic lineStart,
    output logic lineEnd,
    output logic busy,
    output logic noWin,
    output logic [`SST_TW-1:0] fwOpen,
    output logic [`SST_TW-1:0] elapsed,
    output logic [`SST_CNT_W-1:0] frameCnt
);
    sst_pkg::sst_tim_t s;
    sst_pkg::sst_tim_t n;

    function automatic logic [`SST_TW-1:0] usToCyc(input logic [`SST_US_W-1:0] us);
        usToCyc = `SST_TW'(us) * `SST_TW'(`SST_CYC_PER_US);
    endfunction

    function automatic logic [`SST_TW-1:0] minC(input logic [`SST_TW-1:0] a, b);
        minC = (a < b) ? a : b;
    endfunction

    function automatic logic [`SST_TW-1:0] maxC(input logic [`SST_TW-1:0] a, b);
        maxC = (a > b) ? a : b;
    endfunction

    always_comb begin
        logic [`SST_TW-1:0] t;
        logic [`SST_TW-1:0] dlyC;
        logic [`SST_TW-1:0] durEnd;
        n = s;
        t = s.elapsed + `SST_TW'(1);
        dlyC = usToCyc(dlyUs);
        durEnd = dlyC + usToCyc(durUs);
        n.lineStart = 1'b0;
        n.lineEnd = 1'b0;
        case (s.phase)
            sst_pkg::SST_IDLE: begin
                if (trig && enable) begin
                    n.phase = sst_pkg::SST_RUN;
                    n.rolling = rolling;
                    n.flash = flashMode;
                    n.elapsed = '0;
                    n.lines = `SST_LINE_W'(roiHeight) + `SST_LINE_W'(`SST_ROI_PAD);
                    n.expC = usToCyc(expUs);
                    n.fwOpen = rolling ? `SST_TW'(ROW_OFFSET_CYC * (`SST_TW'(n.lines) - 1)) : '0;
                    n.expEnd = n.expC + n.fwOpen;
                    n.noWin = 1'b0;
                    if (rolling && flashMode) begin
                        n.noWin = (n.expC <= n.fwOpen);
                        n.sStart = maxC(n.fwOpen, dlyC);
                        n.sEnd = minC(n.expC, durEnd);
                    end else if (rolling) begin
                        n.sStart = '0;
                        n.sEnd = n.expEnd;
                    end else begin
                        n.sStart = dlyC;
                        n.sEnd = minC(durEnd, n.expEnd);
                    end
                    n.expAct = (n.expEnd != '0);
                    n.strobe = !n.noWin && (n.sStart == '0) && (n.sEnd != '0);
                    n.lineStart = 1'b1;
                    n.startRow = rolling ? `SST_LINE_W'(1) : n.lines;
                    n.startTgt = ROW_OFFSET_CYC;
                    n.endRow = '0;
                    n.endTgt = n.expC;
                    n.frameCnt = s.frameCnt + `SST_CNT_W'(1);
                end
            end
            sst_pkg::SST_RUN: begin
                n.elapsed = t;
                if (s.startRow < s.lines && t == s.startTgt) begin
                    n.lineStart = 1'b1;
                    n.startRow = s.startRow + `SST_LINE_W'(1);
                    n.startTgt = s.startTgt + ROW_OFFSET_CYC;
                end
                if (s.endRow < s.lines && t == s.endTgt) begin
                    n.lineEnd = 1'b1;
                    n.endRow = s.rolling ? s.endRow + `SST_LINE_W'(1) : s.lines;
                    n.endTgt = s.endTgt + ROW_OFFSET_CYC;
                end
                n.expAct = (t < s.expEnd);
                n.strobe = !s.noWin && t >= s.sStart && t < s.sEnd;
                if (t >= s.expEnd) begin
                    n.phase = sst_pkg::SST_IDLE;
                end
            end
            default: n.phase = sst_pkg::SST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign strobe = s.strobe;
    assign expAct = s.expAct;
    assign lineStart = s.lineStart;
    assign lineEnd = s.lineEnd;
    assign busy = (s.phase == sst_pkg::SST_RUN);
    assign noWin = s.noWin;
    assign fwOpen = s.fwOpen;
    assign elapsed = s.elapsed;
    assign frameCnt = s.frameCnt;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence globalStart;
        s.phase == sst_pkg::SST_IDLE && trig && enable && !rolling && expUs != '0;
    endsequence

    flash_in_window_a: assert property (s.strobe && s.rolling && s.flash |->
        s.elapsed >= s.fwOpen && s.elapsed < s.expC) else $error("strobe outside window");
    no_window_quiet_a: assert property (s.noWin |-> !s.strobe)
        else $error("strobe without a flash window");
    line_count_a: assert property (s.phase == sst_pkg::SST_IDLE && trig && enable |=>
        s.lines == `SST_LINE_W'($past(roiHeight)) + `SST_LINE_W'(`SST_ROI_PAD))
        else $error("line count not height plus pad");
    global_expose_a: assert property (globalStart |=>
        s.expAct && s.lineStart && s.startRow == s.lines) else $error("global start wrong");
    expose_end_a: assert property ($fell(s.expAct) && !s.lineStart |->
        s.elapsed == s.expEnd) else $error("exposure ended at wrong count");
    ea_follows_a: assert property (busy && s.rolling && !s.flash |->
        s.strobe == s.expAct) else $error("exposure-active strobe mismatch");
    flash_open_a: assert property (busy && s.rolling && s.flash && !s.noWin &&
        s.elapsed == s.sStart && s.sStart < s.sEnd |-> s.strobe) else $error("flash late");
    row_step_a: assert property (s.lineStart && s.rolling |->
        s.startTgt == s.elapsed + ROW_OFFSET_CYC) else $error("row offset step wrong");
endmodule

// File: src/sst_top.sv
// Implementation choices: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "sst_defs.svh"
module sst_top #(
    // Per-line time in clock cycles; far above 4096, so benches may shorten it.
    parameter logic [`SST_TW-1:0] ROW_OFFSET_CYC = `SST_ROW_OFFSET_CYC
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic frameTrigPin,
    output logic [`SST_N_OUT-1:0] strobePort,
    output logic exposureActive,
    output logic lineStartPulse,
    output logic lineEndPulse
);
    logic rstQ1;
    logic rstQ2;
    logic rstN;
    sst_pkg::sst_regs_t s;
    sst_pkg::sst_regs_t n;
    logic timStrobe;
    logic timExpAct;
    logic timBusy;
    logic timNoWin;
    logic [`SST_TW-1:0] timFwOpen;
    logic [`SST_TW-1:0] timElapsed;
    logic [`SST_CNT_W-1:0] timFrames;
    logic [31:0] statusWord;
    logic frameTrig;

    // The reset is released synchronously so no flop leaves reset on a split edge.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rstQ1 <= 1'b0;
            rstQ2 <= 1'b0;
        end else begin
            rstQ1 <= 1'b1;
            rstQ2 <= rstQ1;
        end
    end

    assign rstN = rstQ2;

    // Hardware trigger and software trigger reach the timer through one path.
    assign frameTrig = s.trigPulse || s.swTrig;

    sst_timing #(
        .ROW_OFFSET_CYC(ROW_OFFSET_CYC)
    ) u_timing (
        .clk(clk),
        .rst_n(rstN),
        .trig(frameTrig),
        .enable(s.en),
        .rolling(s.rolling),
        .flashMode(s.flash),
        .roiHeight(s.roi),
        .expUs(s.expUs),
        .dlyUs(s.dlyUs),
        .durUs(s.durUs),
        .strobe(timStrobe),
        .expAct(timExpAct),
        .lineStart(lineStartPulse),
        .lineEnd(lineEndPulse),
        .busy(timBusy),
        .noWin(timNoWin),
        .fwOpen(timFwOpen),
        .elapsed(timElapsed),
        .frameCnt(timFrames)
    );

    always_comb begin
        statusWord = '0;
        statusWord[`SST_ST_BUSY] = timBusy;
        statusWord[`SST_ST_EXPACT] = timExpAct;
        statusWord[`SST_ST_STROBE] = timStrobe;
        statusWord[`SST_ST_NOWIN] = s.noWinSticky;
        statusWord[`SST_ST_FRAMES_LSB +: `SST_CNT_W] = timFrames;
    end

    function automatic logic [31:0] readReg(
        input logic [`SST_AW-1:0] a,
        input sst_pkg::sst_regs_t r,
        input logic [31:0] st,
        input logic [`SST_TW-1:0] fw,
        input logic [`SST_TW-1:0] el
    );
        logic [31:0] d;
        d = '0;
        if (a == `SST_REG_CTRL) begin
            d[`SST_CTRL_EN] = r.en;
            d[`SST_CTRL_ROLL] = r.rolling;
            d[`SST_CTRL_FLASH] = r.flash;
            d[`SST_CTRL_PORT_LSB +: `SST_N_OUT] = r.portSel;
        end else if (a == `SST_REG_ROI) begin
            d[`SST_ROI_W-1:0] = r.roi;
        end else if (a == `SST_REG_EXPOSURE) begin
            d[`SST_US_W-1:0] = r.expUs;
        end else if (a == `SST_REG_DELAY) begin
            d[`SST_US_W-1:0] = r.dlyUs;
        end else if (a == `SST_REG_DURATION) begin
            d[`SST_US_W-1:0] = r.durUs;
        end else if (a == `SST_REG_STATUS) begin
            d = st;
        end else if (a == `SST_REG_FLASHOPEN) begin
            d = fw;
        end else if (a == `SST_REG_MISSED) begin
            d[`SST_CNT_W-1:0] = r.missed;
        end else if (a == `SST_REG_ELAPSED) begin
            d = el;
        end
        readReg = d;
    endfunction

    always_comb begin
        logic take;
        n = s;
        take = hsel && htrans[1] && hready;

        // Pin trigger: three flops, and a low-to-high change counts once flops two and three agree.
        n.sy1 = frameTrigPin;
        n.sy2 = s.sy1;
        n.sy3 = s.sy2;
        if (s.sy2 == s.sy3) begin
            n.trigLvl = s.sy3;
        end
        n.trigPulse = (s.sy2 == s.sy3) && s.sy3 && !s.trigLvl;
        n.swTrig = 1'b0;

        // Data phase of a write; the address was captured one cycle earlier.
        if (s.dpValid && s.dpWrite) begin
            if (s.dpAddr == `SST_REG_CTRL) begin
                n.en = hwdata[`SST_CTRL_EN];
                n.rolling = hwdata[`SST_CTRL_ROLL];
                n.flash = hwdata[`SST_CTRL_FLASH];
                n.swTrig = hwdata[`SST_CTRL_SWTRIG];
                n.portSel = hwdata[`SST_CTRL_PORT_LSB +: `SST_N_OUT];
            end else if (s.dpAddr == `SST_REG_ROI) begin
                n.roi = hwdata[`SST_ROI_W-1:0];
            end else if (s.dpAddr == `SST_REG_EXPOSURE) begin
                n.expUs = hwdata[`SST_US_W-1:0];
            end else if (s.dpAddr == `SST_REG_DELAY) begin
                n.dlyUs = hwdata[`SST_US_W-1:0];
            end else if (s.dpAddr == `SST_REG_DURATION) begin
                n.durUs = hwdata[`SST_US_W-1:0];
            end else if (s.dpAddr == `SST_REG_STATUS) begin
                if (hwdata[`SST_ST_NOWIN]) begin
                    n.noWinSticky = 1'b0;
                end
            end else if (s.dpAddr == `SST_REG_MISSED) begin
                n.missed = '0;
            end
        end

        // Hardware sets come after the software clears, so a set in the same cycle wins.
        if (timBusy && timNoWin) begin
            n.noWinSticky = 1'b1;
        end
        if (frameTrig && timBusy && s.missed != '1) begin
            n.missed = n.missed + `SST_CNT_W'(1);
        end

        // One window drives every selected port, so all ports share delay and duration.
        n.strobeOut = s.portSel & {`SST_N_OUT{timStrobe}};

        n.dpValid = take;
        if (take) begin
            n.dpWrite = hwrite;
            n.dpAddr = haddr[`SST_AW-1:0];
        end
        // Reads see the value after any write in the same cycle, except a same-cycle clear of the status sticky bit.
        if (take && !hwrite) begin
            n.rdata = readReg(haddr[`SST_AW-1:0], n, statusWord, timFwOpen, timElapsed);
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            s <= '0;
            s.roi <= `SST_ROI_RST;
            s.expUs <= `SST_EXP_RST;
            s.dlyUs <= `SST_DLY_RST;
            s.durUs <= `SST_DUR_RST;
            s.portSel <= `SST_PORT_RST;
        end else begin
            s <= n;
        end
    end

    // The slave never inserts wait states and never signals an error.
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = s.rdata;
    assign strobePort = s.strobeOut;
    assign exposureActive = timExpAct;

    default clocking mcb @(posedge clk); endclocking
    default disable iff (!rstN);

    sequence expWrite;
        hsel && htrans[1] && hready && hwrite && haddr[`SST_AW-1:0] == `SST_REG_EXPOSURE;
    endsequence

    sequence pinRise;
        !s.trigLvl && s.sy2 && s.sy3;
    endsequence

    shared_ports_a: assert property (##1 1'b1 |->
        strobePort == ($past(s.portSel) & {`SST_N_OUT{$past(timStrobe)}}))
        else $error("strobe ports disagree with window");
    exposure_write_a: assert property (expWrite ##1 1'b1 |=>
        s.expUs == $past(hwdata[`SST_US_W-1:0])) else $error("exposure write lost");
    trig_filter_a: assert property (pinRise |=> s.trigPulse && s.trigLvl)
        else $error("agreed pin rise gave no trigger");
    trig_single_a: assert property (s.trigPulse |=> !s.trigPulse)
        else $error("trigger pulse longer than one cycle");
endmodule

// File: verification/sst_lamp.sv
`timescale 1ns/1ps
module sst_lamp (
    input wire logic clk,
    input wire logic clear,
    input wire logic [1:0] lampIn,
    input wire logic expAct,
    output logic [15:0] onCnt0,
    output logic [15:0] onCnt1,
    output logic [15:0] expCnt,
    output logic [15:0] lagCnt
);
    // The lamp only listens, so it can never disturb the camera side.
    logic seen = 1'b0;
    always_ff @(posedge clk) begin
        if (clear) begin
            onCnt0 <= 16'h0000;
            onCnt1 <= 16'h0000;
            expCnt <= 16'h0000;
            lagCnt <= 16'h0000;
            seen <= 1'b0;
        end else begin
            onCnt0 <= onCnt0 + 16'(lampIn[0]);
            onCnt1 <= onCnt1 + 16'(lampIn[1]);
            expCnt <= expCnt + 16'(expAct);
            // Lag counts exposure cycles before lamp input 0 first lights.
            if (lampIn[0]) begin
                seen <= 1'b1;
            end else if (expAct && !seen) begin
                lagCnt <= lagCnt + 16'h0001;
            end
        end
    end
endmodule

// File: verification/tb_shutter_strobe_timing.sv
`timescale 1ns/1ps
`include "sst_defs.svh"
module tb_shutter_strobe_timing;
    localparam int LIMIT = 30000;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h00000000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h00000000;
    wire logic hready;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic pin = 1'b0;
    logic [1:0] strobePort;
    logic exposureActive;
    logic lineStartPulse;
    logic lineEndPulse;
    logic clear = 1'b0;
    logic [15:0] onCnt0;
    logic [15:0] onCnt1;
    logic [15:0] expCnt;
    logic [15:0] lagCnt;
    logic [15:0] lsCnt = 16'h0000;
    logic [15:0] leCnt = 16'h0000;
    int fail_count = 0;
    int total_checks = 0;
    int cycles = 0;

    always #2 clk = ~clk;
    assign hready = hreadyout;

    sst_top #(.ROW_OFFSET_CYC(32'h00000003)) dut (
        .clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .frameTrigPin(pin),
        .strobePort(strobePort), .exposureActive(exposureActive),
        .lineStartPulse(lineStartPulse), .lineEndPulse(lineEndPulse)
    );

    sst_lamp lamp (
        .clk(clk), .clear(clear), .lampIn(strobePort), .expAct(exposureActive),
        .onCnt0(onCnt0), .onCnt1(onCnt1), .expCnt(expCnt), .lagCnt(lagCnt)
    );

    always @(posedge clk) begin
        if (clear) begin
            lsCnt <= 16'h0000;
            leCnt <= 16'h0000;
        end else begin
            lsCnt <= lsCnt + 16'(lineStartPulse);
            leCnt <= leCnt + 16'(lineEndPulse);
        end
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            fail_count++;
            complete_run();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] q);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        hwrite <= wr;
        htrans <= 2'h2;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        q = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        ahb(1'b1, a, d, q);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        ahb(1'b0, a, 32'h00000000, q);
        check(q, e);
        check({31'h0, hresp}, 32'h00000000);
    endtask

    task automatic pulse();
        @(posedge clk);
        pin <= 1'b1;
        repeat (3) @(posedge clk);
        pin <= 1'b0;
    endtask

    // Expected figures assume a row offset of 3 cycles and 250 cycles per microsecond.
    task automatic run_row(input logic [31:0] ctrl, input logic [31:0] roi,
            input logic [31:0] ex, input logic [31:0] dly, input logic [31:0] dur,
            input int on0, input int on1, input int expc, input int lag, input int lines,
            input logic nw, input logic miss);
        logic [31:0] q;
        wr(`SST_REG_ROI, roi);
        wr(`SST_REG_EXPOSURE, ex);
        wr(`SST_REG_DELAY, dly);
        wr(`SST_REG_DURATION, dur);
        wr(`SST_REG_CTRL, ctrl);
        @(posedge clk);
        clear <= 1'b1;
        @(posedge clk);
        clear <= 1'b0;
        pulse();
        while (exposureActive !== 1'b1) @(posedge clk);
        // A second trigger inside a running frame must be refused and counted.
        if (miss) begin
            repeat (30) @(posedge clk);
            pulse();
        end
        while (exposureActive !== 1'b0) @(posedge clk);
        repeat (4) @(posedge clk);
        check(32'(onCnt0), 32'(on0));
        check(32'(onCnt1), 32'(on1));
        check(32'(expCnt), 32'(expc));
        check(32'(lagCnt), 32'(lag));
        check(32'(lsCnt), 32'(lines));
        check(32'(leCnt), 32'(lines));
        ahb(1'b0, `SST_REG_STATUS, 32'h00000000, q);
        check({31'h0, q[`SST_ST_NOWIN]}, {31'h0, nw});
        wr(`SST_REG_STATUS, 32'h00000008);
    endtask

    initial begin
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        repeat (5) @(posedge clk);
        rdchk(`SST_REG_CTRL, 32'h00000100);
        rdchk(`SST_REG_ROI, 32'h00000100);
        rdchk(`SST_REG_EXPOSURE, 32'h000003e8);
        rdchk(`SST_REG_DELAY, 32'h00000000);
        rdchk(`SST_REG_DURATION, 32'h00000064);
        rdchk(`SST_REG_MISSED, 32'h00000000);
        rdchk(8'h40, 32'h00000000);
        // Global shutter: delayed strobe clipped at exposure end.
        run_row(32'h101, 32'h100, 32'h2, 32'h1, 32'h4, 250, 0, 500, 251, 1, 1'b0, 1'b0);
        // Rolling flash window on both ports, then on port 0; long duration cannot widen it.
        run_row(32'h307, 32'h0, 32'h2, 32'h0, 32'ha, 479, 479, 521, 22, 8, 1'b0, 1'b0);
        run_row(32'h107, 32'h0, 32'h2, 32'h0, 32'h1, 229, 0, 521, 22, 8, 1'b0, 1'b0);
        run_row(32'h107, 32'h0, 32'h2, 32'h1, 32'h1, 250, 0, 521, 251, 8, 1'b0, 1'b0);
        // Exposure equal to the open time gives no window; three cycles more gives three.
        run_row(32'h107, 32'hf3, 32'h3, 32'h0, 32'ha, 0, 0, 1500, 1500, 251, 1'b1, 1'b0);
        run_row(32'h107, 32'hf2, 32'h3, 32'h0, 32'ha, 3, 0, 1497, 748, 250, 1'b0, 1'b0);
        // Rolling exposure-active mode ignores delay and duration.
        run_row(32'h103, 32'h0, 32'h2, 32'h1, 32'h1, 521, 0, 521, 1, 8, 1'b0, 1'b1);
        rdchk(`SST_REG_MISSED, 32'h00000001);
        wr(`SST_REG_MISSED, 32'h00000000);
        rdchk(`SST_REG_MISSED, 32'h00000000);
        // Software trigger starts a frame with no pin edge; the bit reads back as zero.
        wr(`SST_REG_CTRL, 32'h0000010b);
        while (exposureActive !== 1'b1) @(posedge clk);
        while (exposureActive !== 1'b0) @(posedge clk);
        rdchk(`SST_REG_CTRL, 32'h00000103);
        rdchk(`SST_REG_STATUS, 32'h00080000);
        // A pin edge while disabled must not start a frame, so the count stays at eight.
        wr(`SST_REG_CTRL, 32'h00000102);
        pulse();
        repeat (10) @(posedge clk);
        rdchk(`SST_REG_STATUS, 32'h00080000);
        complete_run();
    end
endmodule
